// >>> rtl/scs_pkg.sv
package scs_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;

    // register byte addresses
    localparam logic [7:0] REG_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] REG_INPUT_REFERENCE = 8'h04;
    localparam logic [7:0] REG_RESULT_LOW = 8'h08;
    localparam logic [7:0] REG_RESULT_HIGH = 8'h0c;
    localparam logic [1:0] ADDR_ALIGN = 2'h0;

    // decoded register selector
    typedef enum logic [2:0] {
        scs_sel_control = 3'b000,
        scs_sel_select = 3'b001,
        scs_sel_low = 3'b010,
        scs_sel_high = 3'b011,
        scs_sel_none = 3'b100
    } scs_sel_type;

    // control and status field layout
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_START_BIT = 6;
    localparam int CTL_FREE_RUN_BIT = 5;
    localparam int CTL_FLAG_BIT = 4;
    localparam int CTL_IE_BIT = 3;
    localparam int CTL_DIV_LSB = 0;
    localparam int DIV_W = 3;

    // input and reference select field layout
    localparam int SEL_REF_LSB = 6;
    localparam int REF_W = 2;
    localparam int SEL_LEFT_BIT = 5;
    localparam int SEL_CHAN_LSB = 0;
    localparam int CHAN_W = 4;

    // result layout
    localparam int RESULT_W = 10;
    localparam int LEFT_PAD_W = 6;
    localparam int HIGH_PAD_W = 6;

    // conversion timing in converter clock cycles and half cycles
    localparam int HALF_W = 6;
    localparam logic [5:0] NORMAL_CYCLES = 6'h0d;
    localparam logic [5:0] EXTENDED_CYCLES = 6'h19;
    localparam logic [5:0] NORMAL_SH_HALVES = 6'h03;
    localparam logic [5:0] EXTENDED_SH_HALVES = 6'h1b;
    localparam logic [5:0] ONE_HALF = 6'h01;
    localparam logic [5:0] ONE_CYCLE = 6'h01;

    // prescaler
    localparam int PRESC_W = 7;
    localparam logic [DIV_W-1:0] DIV_CODE_FIRST = 3'h0;
    localparam logic [PRESC_W-1:0] PRESC_MASK_MIN = 7'h01;
    localparam logic [PRESC_W:0] PRESC_ONE = 8'h01;
    localparam logic [PRESC_W-1:0] PRESC_STEP = 7'h01;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // conversion sequencer states
    typedef enum logic [1:0] {
        scs_idle = 2'b00,
        scs_armed = 2'b01,
        scs_converting = 2'b10
    } scs_conv_type;

endpackage

// >>> rtl/scs_prescaler.sv
module scs_prescaler
    import scs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [DIV_W-1:0] divider_select,
    // converter clock edges
    output logic rise_tick,
    output logic fall_tick
);

    typedef struct packed {
        logic [PRESC_W-1:0] count;
    } scs_presc_type;

    scs_presc_type r;
    scs_presc_type next_r;
    logic [PRESC_W-1:0] mask;

    // divisor mask from select code, codes 0 and 1 both divide by two
    always_comb
    begin
        if (divider_select == DIV_CODE_FIRST)
            mask = PRESC_MASK_MIN;
        else
            mask = PRESC_W'((PRESC_ONE << divider_select) - PRESC_ONE);
    end

    // counter runs only while enabled, held at zero otherwise
    always_comb
    begin
        next_r = r;
        if (run)
            next_r.count = r.count + PRESC_STEP;
        else
            next_r.count = '0;
    end

    // rising edge at end of a period, falling edge at its middle
    assign rise_tick = run && ((r.count & mask) == mask);
    assign fall_tick = run && ((r.count & mask) == (mask >> 1));

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

endmodule

// >>> rtl/scs_sequencer.sv
// Notes on behaviour
// - prescaler counts while enable is set, held reset while it is low
// - a start waits for the next rising converter clock edge
// - normal conversion lasts 13 converter clock cycles
// - first conversion after enabling lasts 25 converter clock cycles
// - sample-and-hold at 1.5 cycles, or 13.5 for extended conversion
// - completion stores result, sets flag, single mode clears start
// - free-running restarts at once, start keeps reading high
// - selection buffered, copied to active while no conversion runs
// - active selection frozen once a conversion starts
// - copying resumes in the last converter cycle before completion
// - a safe reselection applies to the next conversion
// - free-run: already started conversion keeps the previous channel
// - idle or noise sleep entry starts a conversion in single mode
// - sleep-started conversion still raises its request when it ends
// - other sleep modes leave the converter enabled
// - result code taken unchanged from the analog core
// - divider select codes give 2,2,4,...,128
// - clearing enable aborts a running conversion at once
// - flag clears on vector taken or write of one, zero ignored
// - low byte read blocks updates until high byte read, flag still sets
module scs_sequencer
    import scs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/BYTE_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog core
    input wire logic [RESULT_W-1:0] analog_code,
    output logic [CHAN_W-1:0] channel_select,
    output logic [REF_W-1:0] reference_select,
    output logic sample_hold,
    output logic converter_powered,
    output logic conversion_busy,
    // cpu side
    input wire logic sleep_entry,
    input wire logic vector_taken,
    output logic done_irq
);

    typedef struct packed {
        scs_conv_type state;
        logic converter_enable;
        logic conversion_start;
        logic free_run_select;
        logic conversion_done_flag;
        logic done_interrupt_enable;
        logic [DIV_W-1:0] clock_divider_select;
        logic [REF_W-1:0] temp_reference;
        logic left_adjust;
        logic [CHAN_W-1:0] temp_channel;
        logic [REF_W-1:0] active_reference;
        logic [CHAN_W-1:0] active_channel;
        logic first_pending;
        logic extended;
        logic [HALF_W-1:0] halves;
        logic [RESULT_W-1:0] result;
        logic result_lock;
        logic sample_pulse;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [BYTE_W-1:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
    } scs_regs_type;

    scs_regs_type r;
    scs_regs_type next_r;
    logic rise_tick;
    logic fall_tick;

    // conversion length in half converter cycles
    function automatic logic [HALF_W-1:0] end_halves(input logic ext);
        if (ext)
            return EXTENDED_CYCLES << 1;
        else
            return NORMAL_CYCLES << 1;
    endfunction

    // half cycle of the sample-and-hold instant
    function automatic logic [HALF_W-1:0] sh_halves(input logic ext);
        if (ext)
            return EXTENDED_SH_HALVES;
        else
            return NORMAL_SH_HALVES;
    endfunction

    // half cycle at which the last converter cycle begins
    function automatic logic [HALF_W-1:0] unlock_halves(input logic ext);
        if (ext)
            return (EXTENDED_CYCLES - ONE_CYCLE) << 1;
        else
            return (NORMAL_CYCLES - ONE_CYCLE) << 1;
    endfunction

    // register select from a byte address
    function automatic scs_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = {addr[ADDR_W-1:2], ADDR_ALIGN};
        if (word == REG_CONTROL_STATUS)
            return scs_sel_control;
        else if (word == REG_INPUT_REFERENCE)
            return scs_sel_select;
        else if (word == REG_RESULT_LOW)
            return scs_sel_low;
        else if (word == REG_RESULT_HIGH)
            return scs_sel_high;
        else
            return scs_sel_none;
    endfunction

    // low result byte, right or left adjusted
    function automatic logic [BYTE_W-1:0] low_byte(
        input logic [RESULT_W-1:0] res,
        input logic left
    );
        if (left)
            return {res[1:0], {LEFT_PAD_W{1'b0}}};
        else
            return res[BYTE_W-1:0];
    endfunction

    // high result byte, right or left adjusted
    function automatic logic [BYTE_W-1:0] high_byte(
        input logic [RESULT_W-1:0] res,
        input logic left
    );
        if (left)
            return res[RESULT_W-1:2];
        else
            return {{HIGH_PAD_W{1'b0}}, res[RESULT_W-1:BYTE_W]};
    endfunction

    // converter clock generation
    scs_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(r.converter_enable),
        .divider_select(r.clock_divider_select),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick)
    );

    // sequencer, register file and bus slave
    always_comb
    begin
        logic flag_set;
        logic flag_clear;
        logic locked;
        logic [HALF_W-1:0] half_next;
        logic [BYTE_W-1:0] wd;
        logic [BYTE_W-1:0] rd;
        scs_sel_type wsel;
        scs_sel_type rsel;
        flag_set = 1'b0;
        flag_clear = 1'b0;
        locked = 1'b0;
        half_next = HALF_W'(r.halves + ONE_HALF);
        wd = r.w_byte;
        rd = '0;
        wsel = decode(r.aw_addr);
        rsel = decode(s_axi_araddr);
        next_r = r;
        next_r.sample_pulse = 1'b0;

        // conversion engine on converter clock edges
        case (r.state)
            scs_idle:
            begin
                next_r.halves = '0;
            end
            scs_armed:
            begin
                if (rise_tick)
                begin
                    next_r.state = scs_converting;
                    next_r.halves = '0;
                    next_r.extended = r.first_pending;
                    next_r.first_pending = 1'b0;
                end
            end
            scs_converting:
            begin
                if (rise_tick || fall_tick)
                begin
                    next_r.halves = half_next;
                    if (half_next == sh_halves(r.extended))
                        next_r.sample_pulse = 1'b1;
                end
                if (rise_tick && half_next == end_halves(r.extended))
                begin
                    if (!r.result_lock)
                        next_r.result = analog_code;
                    flag_set = 1'b1;
                    next_r.halves = '0;
                    next_r.extended = 1'b0;
                    if (r.free_run_select)
                    begin
                        next_r.state = scs_converting;
                    end
                    else
                    begin
                        next_r.state = scs_idle;
                        next_r.conversion_start = 1'b0;
                    end
                end
            end
            default:
            begin
                next_r.state = scs_idle;
            end
        endcase

        // selection frozen except in the last cycle of a conversion
        locked = (r.state == scs_converting) &&
            (r.halves < unlock_halves(r.extended));
        if (!locked)
        begin
            next_r.active_channel = r.temp_channel;
            next_r.active_reference = r.temp_reference;
        end

        // sleep entry starts a conversion only in single mode when idle
        if (sleep_entry && r.converter_enable && !r.free_run_select &&
            r.state == scs_idle && !r.conversion_start)
        begin
            next_r.state = scs_armed;
            next_r.conversion_start = 1'b1;
        end

        // write channels taken independently
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_r.w_held = 1'b1;
            next_r.w_byte = s_axi_wdata[BYTE_W-1:0];
            next_r.w_lane = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready)
            next_r.bvalid = 1'b0;

        // perform a write once address and data are both held
        if (r.aw_held && r.w_held && !r.bvalid)
        begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = (wsel == scs_sel_none) ? RESP_SLVERR : RESP_OKAY;
            if (r.w_lane && wsel == scs_sel_control)
            begin
                next_r.converter_enable = wd[CTL_ENABLE_BIT];
                next_r.free_run_select = wd[CTL_FREE_RUN_BIT];
                next_r.done_interrupt_enable = wd[CTL_IE_BIT];
                next_r.clock_divider_select =
                    wd[CTL_DIV_LSB +: DIV_W];
                flag_clear = wd[CTL_FLAG_BIT];
                if (!r.converter_enable && wd[CTL_ENABLE_BIT])
                    next_r.first_pending = 1'b1;
                if (wd[CTL_ENABLE_BIT] && wd[CTL_START_BIT] &&
                    r.state == scs_idle)
                begin
                    next_r.state = scs_armed;
                    next_r.conversion_start = 1'b1;
                end
                if (!wd[CTL_ENABLE_BIT])
                begin
                    next_r.state = scs_idle;
                    next_r.conversion_start = 1'b0;
                    next_r.first_pending = 1'b0;
                    next_r.extended = 1'b0;
                    next_r.halves = '0;
                    next_r.sample_pulse = 1'b0;
                end
            end
            else if (r.w_lane && wsel == scs_sel_select)
            begin
                next_r.temp_reference = wd[SEL_REF_LSB +: REF_W];
                next_r.left_adjust = wd[SEL_LEFT_BIT];
                next_r.temp_channel = wd[SEL_CHAN_LSB +: CHAN_W];
            end
        end

        // read channel, result bytes carry the lock side effects
        if (r.rvalid && s_axi_rready)
            next_r.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            if (rsel == scs_sel_control)
            begin
                rd[CTL_ENABLE_BIT] = r.converter_enable;
                rd[CTL_START_BIT] = r.conversion_start;
                rd[CTL_FREE_RUN_BIT] = r.free_run_select;
                rd[CTL_FLAG_BIT] = r.conversion_done_flag;
                rd[CTL_IE_BIT] = r.done_interrupt_enable;
                rd[CTL_DIV_LSB +: DIV_W] = r.clock_divider_select;
            end
            else if (rsel == scs_sel_select)
            begin
                rd[SEL_REF_LSB +: REF_W] = r.temp_reference;
                rd[SEL_LEFT_BIT] = r.left_adjust;
                rd[SEL_CHAN_LSB +: CHAN_W] = r.temp_channel;
            end
            else if (rsel == scs_sel_low)
            begin
                rd = low_byte(r.result, r.left_adjust);
                next_r.result_lock = 1'b1;
            end
            else if (rsel == scs_sel_high)
            begin
                rd = high_byte(r.result, r.left_adjust);
                next_r.result_lock = 1'b0;
            end
            else
            begin
                next_r.rresp = RESP_SLVERR;
            end
            next_r.rdata = DATA_W'(rd);
        end

        // flag: a completion in the clearing cycle wins
        flag_clear = flag_clear || vector_taken;
        next_r.conversion_done_flag =
            (r.conversion_done_flag && !flag_clear) || flag_set;
    end

    // bus handshake outputs
    assign s_axi_awready = !r.aw_held && !r.bvalid;
    assign s_axi_wready = !r.w_held && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;

    // analog and cpu side outputs
    assign channel_select = r.active_channel;
    assign reference_select = r.active_reference;
    assign sample_hold = r.sample_pulse;
    assign converter_powered = r.converter_enable;
    assign conversion_busy = (r.state == scs_converting);
    assign done_irq = r.conversion_done_flag && r.done_interrupt_enable;

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

endmodule

// >>> testbench/scs_analog_model.sv
module scs_analog_model
    import scs_pkg::*;
(
    // clock
    input wire logic aclk,
    // selection and sample instant from the block
    input wire logic [CHAN_W-1:0] channel_select,
    input wire logic [REF_W-1:0] reference_select,
    input wire logic sample_hold,
    // level of the test source
    input wire logic [3:0] level,
    // held result towards the block
    output logic [RESULT_W-1:0] analog_code
);
    timeunit 1ns;
    timeprecision 100ps;

    // code of the held sample, built so the bench can tell what was taken
    initial analog_code = 10'h000;
    always @(posedge aclk)
    begin
        if (sample_hold)
        begin
            analog_code <= {reference_select, channel_select, level};
        end
    end
endmodule

// >>> testbench/scs_checker_properties.sv
module scs_checker
    import scs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // converter side
    input wire logic [CHAN_W-1:0] channel_select,
    input wire logic [REF_W-1:0] reference_select,
    input wire logic sample_hold,
    input wire logic converter_powered,
    input wire logic conversion_busy,
    input wire logic done_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_busy_needs_enable: assert property (
        conversion_busy |-> converter_powered)
        else $error("busy while converter off");
    a_start_after_tick: assert property (
        $rose(conversion_busy) |-> $past(converter_powered, 2))
        else $error("start without converter clock edge");
    a_hold_not_early: assert property (
        $rose(conversion_busy) |-> !sample_hold [*3])
        else $error("sample taken too early");
    a_hold_one_pulse: assert property (
        $rose(sample_hold) |-> $past(conversion_busy) ##1 !sample_hold)
        else $error("sample pulse outside conversion");
    a_select_frozen: assert property (
        $rose(conversion_busy) |=> !conversion_busy
            || ($stable(channel_select) && $stable(reference_select)))
        else $error("selection moved after start");
    a_abort_at_once: assert property (
        $fell(converter_powered) |-> !conversion_busy)
        else $error("conversion survived disable");
    a_irq_has_cause: assert property (
        $rose(done_irq) |-> $past(conversion_busy) || $rose(s_axi_bvalid))
        else $error("request without completion or write");
    a_read_one_cycle: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
endmodule

bind scs_sequencer scs_checker chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .channel_select(channel_select), .reference_select(reference_select),
    .sample_hold(sample_hold), .converter_powered(converter_powered),
    .conversion_busy(conversion_busy), .done_irq(done_irq));

// >>> testbench/testbench.sv
module testbench
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, sleep_entry = 1'h0;
    logic vector_taken = 1'h0, auto_clear = 1'h0;
    logic busy_d = 1'h0, irq_d = 1'h0;
    logic [3:0] wstrb = 4'hf, level = 4'h0, chan;
    logic awready, wready, bvalid, arready, rvalid, sh, pwr, busy, irq;
    logic [1:0] bresp, rresp, rsel, refsel;
    logic [9:0] code;
    int n_errors = 0, num_checks = 0, seed = 17, cyc = 0, t_busy, t_sh;
    int irq_at[$];
    logic [3:0] sh_chan[$];

    // clock
    initial
        forever #2 aclk = ~aclk;

    scs_sequencer dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .analog_code(code), .channel_select(chan),
        .reference_select(refsel), .sample_hold(sh),
        .converter_powered(pwr), .conversion_busy(busy),
        .sleep_entry(sleep_entry), .vector_taken(vector_taken),
        .done_irq(irq));
    scs_analog_model partner (.aclk(aclk), .channel_select(chan),
        .reference_select(refsel), .sample_hold(sh), .level(level),
        .analog_code(code));

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end
        while (!bvalid);
        bready <= 1'h0;
        check(bresp, RESP_OKAY, "bresp");
    endtask

    // bus read: answer taken at the edge that sees rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end
        while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        rsel = rresp;
    endtask

    task automatic wait_irq(input int n);
        int t;
        t = 0;
        while (irq_at.size() < n && t < 9000)
        begin
            @(posedge aclk);
            t++;
        end
        check(irq_at.size() >= n, 1'h1, "request");
    endtask

    // timing of the finished conversion and its result bytes
    task automatic done_check(input int d, n, h, input logic [9:0] c,
                              input logic lf);
        logic [31:0] v;
        wait_irq(1);
        check(irq_at[0] - t_busy, n * d, "length");
        check(t_sh - t_busy, h * d / 2, "sample");
        rd(REG_RESULT_LOW, v);
        check(v, lf ? {24'h0, c[1:0], 6'h0} : {24'h0, c[7:0]}, "low");
        rd(REG_RESULT_HIGH, v);
        check(v, lf ? {24'h0, c[9:2]} : {30'h0, c[9:8]}, "high");
        irq_at.delete();
    endtask

    // event times, clearing vector and timeout
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (busy && !busy_d) t_busy = cyc;
        if (sh)
        begin
            t_sh = cyc;
            sh_chan.push_back(chan);
        end
        if (irq && !irq_d) irq_at.push_back(cyc);
        busy_d <= busy;
        irq_d <= irq;
        vector_taken <= auto_clear && irq && !vector_taken;
        if (cyc > 60000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        logic [31:0] v;
        logic [3:0] lv, nch;
        logic [1:0] rf;
        int d, t;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(REG_CONTROL_STATUS, v);
        check(v, 32'h0, "control reset");
        rd(8'h10, v);
        check(rsel, RESP_SLVERR, "unmapped");
        check(v, 32'h0, "unmapped data");
        // a write with its low lane off is answered but changes nothing
        wstrb <= 4'h0;
        wr(REG_CONTROL_STATUS, 8'hc0);
        wstrb <= 4'hf;
        rd(REG_CONTROL_STATUS, v);
        check(v, 32'h0, "lane off");
        // every divider code: extended then normal conversion
        for (int k = 0; k < 8; k++)
        begin
            d = (k < 2) ? 2 : (1 << k);
            lv = (k == 0) ? 4'h0 : (k == 7) ? 4'hf : 4'($random(seed));
            nch = 4'($random(seed));
            rf = 2'(k);
            level <= lv;
            wr(REG_INPUT_REFERENCE, {rf, k[0], 1'h0, lv});
            wr(REG_CONTROL_STATUS, 8'hc8 | 8'(k));
            t = 0;
            while (!busy && t < 999)
            begin
                @(posedge aclk);
                t++;
            end
            wr(REG_INPUT_REFERENCE, {rf, k[0], 1'h0, nch});
            check(chan, lv, "frozen");
            done_check(d, 25, 27, {rf, lv, lv}, k[0]);
            wr(REG_CONTROL_STATUS, 8'hd8 | 8'(k));
            done_check(d, 13, 3, {rf, nch, lv}, k[0]);
            wr(REG_CONTROL_STATUS, 8'h88 | 8'(k));
            rd(REG_CONTROL_STATUS, v);
            check(v, 32'h98 | k, "flag kept");
            wr(REG_CONTROL_STATUS, 8'h10);
            rd(REG_CONTROL_STATUS, v);
            check(v, 32'h0, "flag cleared");
        end
        // free run, vector clears the flag, channel changed after first
        sh_chan.delete();
        irq_at.delete();
        auto_clear <= 1'h1;
        wr(REG_INPUT_REFERENCE, 8'h03);
        wr(REG_CONTROL_STATUS, 8'he8);
        wait_irq(1);
        wr(REG_INPUT_REFERENCE, 8'h05);
        wait_irq(3);
        rd(REG_CONTROL_STATUS, v);
        check(v[6], 1'h1, "start stays");
        check(irq_at[2] - irq_at[1], 26, "restart");
        check(sh_chan[1], 4'h3, "old channel");
        check(sh_chan[2], 4'h5, "new channel");
        wr(REG_CONTROL_STATUS, 8'h10);
        check(busy, 1'h0, "abort");
        rd(REG_CONTROL_STATUS, v);
        check(v, 32'h0, "aborted");
        auto_clear <= 1'h0;
        // low byte read blocks the next update, flag still sets
        irq_at.delete();
        level <= 4'h2;
        wr(REG_INPUT_REFERENCE, 8'h21);
        wr(REG_CONTROL_STATUS, 8'hc8);
        wait_irq(1);
        rd(REG_RESULT_LOW, v);
        level <= 4'h9;
        wr(REG_CONTROL_STATUS, 8'hd8);
        wait_irq(2);
        rd(REG_RESULT_HIGH, v);
        check(v, 32'h04, "locked");
        // sleep entry starts a single conversion
        irq_at.delete();
        wr(REG_CONTROL_STATUS, 8'h98);
        sleep_entry <= 1'h1;
        @(posedge aclk);
        sleep_entry <= 1'h0;
        done_check(2, 13, 3, 10'h019, 1'h1);
        complete_run();
    end
endmodule
